// >>> hw/ppr_pkg.sv
// Package: register map, field layout and types of the peripheral pin routing block
package ppr_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int N_IN   = 8;              // Routed peripheral inputs
    localparam int N_PIN  = 8;              // Remappable pins
    localparam int N_POUT = 8;              // Peripheral outputs that can drive a pin
    localparam int SEL_W  = 4;              // Width of a select field
    localparam int ADDR_W = 8;              // Byte address width

    // ****************************************
    // Register map (byte addresses, one word each)
    // ****************************************
    localparam logic [7:0] OFS_CFG     = 8'h00;  // config_control_reg
    localparam logic [7:0] OFS_IN_BASE = 8'h40;  // peripheral_input_route_select[0]
    localparam logic [7:0] OFS_PIN_BASE= 8'h80;  // pin_output_route_select[0]

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int LOCK_BIT = 13;                    // routing_lock_bit position
    localparam int SEL_LSB  = 0;                     // Select field sits in bits 3-0
    localparam logic [3:0]  SEL_RST  = 4'h0;
    localparam logic        LOCK_RST = 1'b0;

    // Register bus request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ppr_req_t;

endpackage

// >>> hw/ppr_routing.sv
// Module: peripheral pin routing with lockable select registers
`timescale 1ns/100ps

module ppr_routing (
    // Clock and reset
    input  wire logic                                     i_clk,
    input  wire logic                                     i_reset_n,
    // Register port
    input  wire logic [7:0]                               i_addr,
    input  wire logic [31:0]                              i_wdata,
    input  wire logic                                     i_wr,
    input  wire logic                                     i_rd,
    output logic      [31:0]                              o_rdata,
    // Pins and peripherals
    input  wire logic [ppr_pkg::N_PIN-1:0]                i_pin,
    input  wire logic [ppr_pkg::N_POUT-1:0]               i_periph_out,
    output logic      [ppr_pkg::N_IN-1:0]                 o_periph_in,
    output logic      [ppr_pkg::N_PIN-1:0]                o_pin,
    output logic                                          o_lock
);

    // ****************************************
    // Register file
    // ****************************************
    ppr_pkg::ppr_req_t req;
    logic [3:0]        in_sel_q  [ppr_pkg::N_IN];
    logic [3:0]        pin_sel_q [ppr_pkg::N_PIN];
    logic              lock_q;
    logic [31:0]       rdata_d;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // Index decode shared by both select banks
    function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int idx);
        hit = (a == base + 8'(idx * 4));
    endfunction

    // Range check shared by both banks: codes past the last source route a low level
    function automatic logic sel_ok(input logic [3:0] s, input int n);
        sel_ok = (s < 4'(n));
    endfunction

    wire cfg_hit = (req.addr == ppr_pkg::OFS_CFG);
    // Locked writes are dropped so a runaway task cannot reroute pins
    wire sel_wr_ok = req.wr && !lock_q;
    wire [3:0] wsel = req.wdata[ppr_pkg::SEL_LSB +: ppr_pkg::SEL_W];

    // Lock bit lives in the configuration register and is never locked itself
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lock_q <= ppr_pkg::LOCK_RST;
        end else if (req.wr && cfg_hit) begin
            lock_q <= req.wdata[ppr_pkg::LOCK_BIT];
        end
    end

    // ****************************************
    // Select banks and routing
    // ****************************************
    // Per-slot enables and routed levels are nets, each bit driven by its own generate slot
    wire [ppr_pkg::N_IN-1:0]  in_wr_en;
    wire [ppr_pkg::N_PIN-1:0] pin_wr_en;
    wire [ppr_pkg::N_IN-1:0]  routed_in;
    wire [ppr_pkg::N_PIN-1:0] routed_pin;

    genvar g;
    generate
        // Input side: the register of an input alone picks its source pin
        for (g = 0; g < ppr_pkg::N_IN; g++) begin : g_in
            assign in_wr_en[g]  = sel_wr_ok && hit(req.addr, ppr_pkg::OFS_IN_BASE, g);
            // Codes beyond the pin count select nothing and give a low level
            assign routed_in[g] = sel_ok(in_sel_q[g], ppr_pkg::N_PIN) ? i_pin[in_sel_q[g][2:0]] : 1'b0;
        end
        // Output side: the register of a pin picks the peripheral output driving it
        for (g = 0; g < ppr_pkg::N_PIN; g++) begin : g_pin
            assign pin_wr_en[g]  = sel_wr_ok && hit(req.addr, ppr_pkg::OFS_PIN_BASE, g);
            // Codes beyond the output count leave the pin low
            assign routed_pin[g] = sel_ok(pin_sel_q[g], ppr_pkg::N_POUT) ? i_periph_out[pin_sel_q[g][2:0]] : 1'b0;
        end
    endgenerate

    // ****************************************
    // Select registers
    // ****************************************
    // One process holds both banks, so every slot has exactly one driver
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            // Default routing: every input from pin 0, every pin from output 0
            for (int k = 0; k < ppr_pkg::N_IN; k++) begin
                in_sel_q[k] <= ppr_pkg::SEL_RST;
            end
            for (int k = 0; k < ppr_pkg::N_PIN; k++) begin
                pin_sel_q[k] <= ppr_pkg::SEL_RST;
            end
        end else begin
            // Locked writes never raise an enable, so the slots keep their value
            for (int k = 0; k < ppr_pkg::N_IN; k++) begin
                if (in_wr_en[k]) begin
                    in_sel_q[k] <= wsel;
                end
            end
            for (int k = 0; k < ppr_pkg::N_PIN; k++) begin
                if (pin_wr_en[k]) begin
                    pin_sel_q[k] <= wsel;
                end
            end
        end
    end

    // Routed levels leave flip-flops; this costs one cycle of latency on every path
    // but keeps the select muxes out of the pin timing
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_periph_in <= '0;
            o_pin       <= '0;
        end else begin
            o_periph_in <= routed_in;
            o_pin       <= routed_pin;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Unmapped addresses read as zero; select words carry only bits 3-0
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (cfg_hit) begin
            rdata_d[ppr_pkg::LOCK_BIT] = lock_q;
        end
        for (int k = 0; k < ppr_pkg::N_IN; k++) begin
            if (hit(req.addr, ppr_pkg::OFS_IN_BASE, k)) begin
                rdata_d[3:0] = in_sel_q[k];
            end
        end
        for (int k = 0; k < ppr_pkg::N_PIN; k++) begin
            if (hit(req.addr, ppr_pkg::OFS_PIN_BASE, k)) begin
                rdata_d[3:0] = pin_sel_q[k];
            end
        end
    end

    // Read data holds zero outside the answer cycle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 32'h0000_0000;
            o_lock  <= 1'b0;
        end else begin
            o_rdata <= req.rd ? rdata_d : 32'h0000_0000;
            o_lock  <= lock_q;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    AST_LOCKED_IN: assert property (lock_q && i_wr |=> $stable(in_sel_q[0]))
        else $error("input select changed while locked");
    AST_LOCKED_PIN: assert property (lock_q && i_wr |=> $stable(pin_sel_q[0]))
        else $error("pin select changed while locked");
    AST_IN_WRITE: assert property (!lock_q && i_wr && i_addr == ppr_pkg::OFS_IN_BASE
        |=> in_sel_q[0] == $past(i_wdata[3:0]))
        else $error("input select write lost");
    AST_PIN_WRITE: assert property (!lock_q && i_wr && i_addr == ppr_pkg::OFS_PIN_BASE
        |=> pin_sel_q[0] == $past(i_wdata[3:0]))
        else $error("pin select write lost");
    AST_UPPER_ZERO: assert property (i_rd && i_addr >= ppr_pkg::OFS_IN_BASE |=> o_rdata[31:4] == 28'h0)
        else $error("select upper bits not zero");
    AST_READBACK: assert property (i_rd && i_addr == ppr_pkg::OFS_IN_BASE |=> o_rdata[3:0] == $past(in_sel_q[0]))
        else $error("select readback mismatch");
    AST_ROUTE_IN: assert property (in_sel_q[0] == 4'h3 ##0 $stable(in_sel_q[0]) |=> o_periph_in[0] == $past(i_pin[3]))
        else $error("input not taken from selected pin");
    AST_ROUTE_OWN: assert property (in_sel_q[1] == 4'h2 |=> o_periph_in[1] == $past(i_pin[2]))
        else $error("input routed by foreign register");
    AST_ROUTE_PIN: assert property (pin_sel_q[2] == 4'h5 |=> o_pin[2] == $past(i_periph_out[5]))
        else $error("pin not driven by selected output");
    AST_RESET_ZERO: assert property ($rose(i_reset_n) |-> in_sel_q[0] == 4'h0 && pin_sel_q[0] == 4'h0)
        else $error("select not zero after reset");

    COV_LOCK: cover property (lock_q && i_wr && i_addr == ppr_pkg::OFS_IN_BASE);
    COV_IN_WR: cover property (!lock_q && i_wr && i_addr == ppr_pkg::OFS_IN_BASE);
    COV_PIN_RD: cover property (i_rd && i_addr == ppr_pkg::OFS_PIN_BASE);
    COV_PIN_WR: cover property (!lock_q && i_wr && i_addr == ppr_pkg::OFS_PIN_BASE);
    COV_UNLOCK: cover property (lock_q && i_wr && i_addr == ppr_pkg::OFS_CFG && !i_wdata[ppr_pkg::LOCK_BIT]);

    // ****************************************
    // Lock bit and read port
    // ****************************************
    // The lock word stays writable, otherwise a set lock could never be undone
    AST_LOCK_TAKE: assert property (i_wr && i_addr == ppr_pkg::OFS_CFG
        |=> lock_q == $past(i_wdata[ppr_pkg::LOCK_BIT]))
        else $error("lock bit write lost");

    // Only a write to the configuration word may move the lock
    AST_LOCK_KEEP: assert property (!(i_wr && i_addr == ppr_pkg::OFS_CFG)
        |=> $stable(lock_q))
        else $error("lock bit changed without a write");

    // The lock output is a registered copy, one cycle behind
    AST_LOCK_OUT: assert property (1'b1
        |=> o_lock == $past(lock_q))
        else $error("lock output does not follow lock bit");

    // Software reads the lock back at its own bit position
    AST_CFG_READ: assert property (i_rd && i_addr == ppr_pkg::OFS_CFG
        |=> o_rdata[ppr_pkg::LOCK_BIT] == $past(lock_q))
        else $error("lock bit readback mismatch");

    // Read data stand for one cycle only, so a stale word cannot be taken twice
    AST_RD_IDLE: assert property (!i_rd
        |=> o_rdata == 32'h0000_0000)
        else $error("read data not zero outside answer cycle");

    // Routing must be programmable straight after reset
    AST_LOCK_RESET: assert property ($rose(i_reset_n)
        |-> lock_q == ppr_pkg::LOCK_RST)
        else $error("lock bit not clear after reset");

    // ****************************************
    // Per-slot assertions
    // ****************************************
    // Every slot is checked, not only slot 0, so a broken index decode cannot hide
    generate
        // Input slots
        for (g = 0; g < ppr_pkg::N_IN; g++) begin : g_ast_in
            // A set lock freezes the slot whatever the bus does
            AST_IN_HOLD: assert property (lock_q
                |=> $stable(in_sel_q[g]))
                else $error("input select changed while locked");

            // An unlocked write to this slot's word lands in bits 3-0
            AST_IN_TAKE: assert property (!lock_q && i_wr && i_addr == ppr_pkg::OFS_IN_BASE + 8'(g * 4)
                |=> in_sel_q[g] == $past(i_wdata[3:0]))
                else $error("input select write lost");

            // Writes to any other word leave this slot alone
            AST_IN_OWN: assert property (!(i_wr && i_addr == ppr_pkg::OFS_IN_BASE + 8'(g * 4))
                |=> $stable(in_sel_q[g]))
                else $error("input select moved by a foreign write");

            // A code within the pin range passes that pin one cycle later
            AST_IN_ROUTE: assert property (!in_sel_q[g][3]
                |=> o_periph_in[g] == $past(i_pin[in_sel_q[g][2:0]]))
                else $error("input not taken from selected pin");

            // Codes past the last pin give a steady low
            AST_IN_NONE: assert property (in_sel_q[g][3]
                |=> !o_periph_in[g])
                else $error("unused input code does not give low");

            // Readback returns the slot with the upper bits zero
            AST_IN_READ: assert property (i_rd && i_addr == ppr_pkg::OFS_IN_BASE + 8'(g * 4)
                |=> o_rdata == {28'h000_0000, $past(in_sel_q[g])})
                else $error("input select readback mismatch");

            // Reset leaves the default route in place
            AST_IN_RESET: assert property ($rose(i_reset_n)
                |-> in_sel_q[g] == ppr_pkg::SEL_RST)
                else $error("input select not zero after reset");
        end
        // Pin slots
        for (g = 0; g < ppr_pkg::N_PIN; g++) begin : g_ast_pin
            // A set lock freezes the slot whatever the bus does
            AST_PIN_HOLD: assert property (lock_q
                |=> $stable(pin_sel_q[g]))
                else $error("pin select changed while locked");

            // An unlocked write to this slot's word lands in bits 3-0
            AST_PIN_TAKE: assert property (!lock_q && i_wr && i_addr == ppr_pkg::OFS_PIN_BASE + 8'(g * 4)
                |=> pin_sel_q[g] == $past(i_wdata[3:0]))
                else $error("pin select write lost");

            // Writes to any other word leave this slot alone
            AST_PIN_OWN: assert property (!(i_wr && i_addr == ppr_pkg::OFS_PIN_BASE + 8'(g * 4))
                |=> $stable(pin_sel_q[g]))
                else $error("pin select moved by a foreign write");

            // A code within the output range drives the pin one cycle later
            AST_PIN_ROUTE: assert property (!pin_sel_q[g][3]
                |=> o_pin[g] == $past(i_periph_out[pin_sel_q[g][2:0]]))
                else $error("pin not driven by selected output");

            // Codes past the last output give a steady low
            AST_PIN_NONE: assert property (pin_sel_q[g][3]
                |=> !o_pin[g])
                else $error("unused pin code does not give low");

            // Readback returns the slot with the upper bits zero
            AST_PIN_READ: assert property (i_rd && i_addr == ppr_pkg::OFS_PIN_BASE + 8'(g * 4)
                |=> o_rdata == {28'h000_0000, $past(pin_sel_q[g])})
                else $error("pin select readback mismatch");

            // Reset leaves the default route in place
            AST_PIN_RESET: assert property ($rose(i_reset_n)
                |-> pin_sel_q[g] == ppr_pkg::SEL_RST)
                else $error("pin select not zero after reset");
        end
    endgenerate

endmodule

// >>> bench/tb_ppr_routing.sv
// Testbench: self-checking bench of the peripheral pin routing block
`timescale 1ns/100ps
module tb_ppr_routing;
    logic        i_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [7:0]  i_pin = 8'h00;
    logic [7:0]  i_periph_out = 8'h00;
    logic [31:0] o_rdata;
    logic [7:0]  o_periph_in;
    logic [7:0]  o_pin;
    logic        o_lock;
    logic [15:0] seed = 16'hd649;
    logic [3:0]  sel [16];
    int          bad_count = 0;
    int          checks = 0;

    ppr_routing ppr_routing_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(i_pin), .i_periph_out(i_periph_out),
        .o_periph_in(o_periph_in), .o_pin(o_pin), .o_lock(o_lock));

    // ****************************************
    // Clock, helpers and bus tasks
    // ****************************************
    always #12.5 i_clk = ~i_clk;

    // Entries 0-7 are input selects, 8-15 pin selects, so one table covers both
    function automatic logic [7:0] adr(input int k);
        return (k < 8 ? ppr_pkg::OFS_IN_BASE : ppr_pkg::OFS_PIN_BASE) + 8'((k % 8) * 4);
    endfunction
    // Codes 8 to 15 route a constant 0
    function automatic logic route(input logic [7:0] v, input logic [3:0] s);
        return s[3] ? 1'b0 : v[s[2:0]];
    endfunction
    task automatic get_rnd(output logic [31:0] r);
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        r[15:0] = seed;
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        r[31:16] = seed;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic route_chk();
        logic [31:0] r;
        get_rnd(r);
        @(posedge i_clk);
        i_pin <= r[7:0];
        i_periph_out <= r[15:8];
        @(posedge i_clk);
        #1;
        for (int k = 0; k < 8; k++) begin
            chk(o_periph_in[k], route(r[7:0], sel[k]));
            chk(o_pin[k], route(r[15:8], sel[k+8]));
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        #(25 * 5000);
        bad_count++;
        wrap_up();
    end
    initial begin
        logic [31:0] r;
        logic [31:0] v;
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            sel[k] = 4'h0;
            rd(adr(k), v);
            chk(v, 32'h0);
        end
        route_chk();
        rd(8'h3c, v);
        chk(v, 32'h0);  // Unmapped address reads zero
        // First round holds the boundary codes 15 and 7, later rounds are random
        for (int n = 0; n < 5; n++) begin
            for (int k = 0; k < 16; k++) begin
                get_rnd(r);
                if (n == 0) r = k[0] ? 32'hffffffff : 32'h00000007;
                wr(adr(k), r);
                sel[k] = r[3:0];
            end
            for (int k = 0; k < 16; k++) begin
                rd(adr(k), v);
                chk(v, {28'h0, sel[k]});
            end
            route_chk();
        end
        wr(ppr_pkg::OFS_CFG, 32'h00002000);
        @(posedge i_clk);
        #1 chk(o_lock, 1'b1);
        for (int k = 0; k < 16; k++) begin
            wr(adr(k), {28'h0, ~sel[k]});
            rd(adr(k), v);
            chk(v, {28'h0, sel[k]});
        end
        route_chk();
        wr(ppr_pkg::OFS_CFG, 32'h0);
        wr(adr(9), {28'h0, ~sel[9]});
        sel[9] = ~sel[9];
        rd(adr(9), v);
        chk(v, {28'h0, sel[9]});
        route_chk();
        // Hand-picked codes that the routing assertions watch closely
        wr(adr(0), 32'h00000003);
        wr(adr(1), 32'h00000002);
        wr(adr(10), 32'h00000005);
        sel[0] = 4'h3;
        sel[1] = 4'h2;
        sel[10] = 4'h5;
        rd(adr(10), v);
        chk(v, 32'h00000005);
        route_chk();
        wrap_up();
    end
endmodule
